// [design/bstr_cfg.svh]
`ifndef BSTR_CFG_SVH
`define BSTR_CFG_SVH

// ********************************************************************
// Widths and fixed patterns
// ********************************************************************
`define BSTR_IR_LEN 8
`define BSTR_BSR_LEN 48
`define BSTR_ID_LEN 32
`define BSTR_IR_CAPTURE 8'h81
`define BSTR_IR_RESET 8'h81
`define BSTR_OE_MSB 47
`define BSTR_OE_LSB 44
`define BSTR_OE_RESET 4'hf
`define BSTR_BYPASS_CAPTURE 1'b0
// Arbitrary neutral identification value; bit 0 kept at one.
`define BSTR_ID_DEFAULT 32'h1000_0001

// ********************************************************************
// Instruction codes
// ********************************************************************
`define BSTR_OP_EXTEST 8'h00
`define BSTR_OP_IDCODE 8'h81
`define BSTR_OP_SAMPLE 8'h82
`define BSTR_OP_HIGHZ 8'h06
`define BSTR_OP_CLAMP 8'h87

`endif

// [design/bstr_pkg.sv]
package bstr_pkg;

    // ****************************************************************
    // Controller states
    // ****************************************************************
    typedef enum logic [3:0] {
        ST_RESET = 4'h0,
        ST_IDLE = 4'h1,
        ST_SEL_DR = 4'h3,
        ST_CAP_DR = 4'h2,
        ST_SHIFT_DR = 4'h6,
        ST_EXIT1_DR = 4'h7,
        ST_PAUSE_DR = 4'h5,
        ST_EXIT2_DR = 4'h4,
        ST_UPD_DR = 4'hc,
        ST_SEL_IR = 4'hd,
        ST_CAP_IR = 4'hf,
        ST_SHIFT_IR = 4'he,
        ST_EXIT1_IR = 4'ha,
        ST_PAUSE_IR = 4'hb,
        ST_EXIT2_IR = 4'h9,
        ST_UPD_IR = 4'h8
    } bstr_state_t;

    // ****************************************************************
    // Test access pins after synchronisation
    // ****************************************************************
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } bstr_pins_t;

endpackage

// [design/bstr_tap.sv]
`timescale 1ns/1ns
`include "bstr_cfg.svh"
module bstr_tap #(
    parameter logic [`BSTR_ID_LEN-1:0] ID_VALUE = `BSTR_ID_DEFAULT
) (
    // Clock, reset and enable
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    // Test access pins
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe_n,
    // Boundary pin levels, one cell per pin
    input wire logic [`BSTR_BSR_LEN-1:0] pin_level,
    // Boundary drive values and mode
    output logic [`BSTR_BSR_LEN-1:0] cell_drive,
    output logic test_mode,
    output logic [3:0] port_drive
);

    // ****************************************************************
    // Pin synchronisers and test clock edges
    // ****************************************************************
    bstr_pkg::bstr_pins_t pins_meta;
    bstr_pkg::bstr_pins_t pins_s;
    logic tck_d;
    logic [`BSTR_BSR_LEN-1:0] level_meta;
    logic [`BSTR_BSR_LEN-1:0] level_s;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pins_meta <= '0;
            pins_s <= '0;
            tck_d <= 1'b0;
            level_meta <= '0;
            level_s <= '0;
        end else if (clk_en) begin
            pins_meta <= '{tck: tck, tms: tms, tdi: tdi};
            pins_s <= pins_meta;
            tck_d <= pins_s.tck;
            level_meta <= pin_level;
            level_s <= level_meta;
        end
    end

    // Controller, shift registers and tdo move on these two strobes only; mode and reset loads follow clk_en.
    wire tck_rise = clk_en & pins_s.tck & ~tck_d;
    wire tck_fall = clk_en & ~pins_s.tck & tck_d;
    wire tms_s = pins_s.tms;
    wire tdi_s = pins_s.tdi;

    // ****************************************************************
    // Controller
    // ****************************************************************
    bstr_pkg::bstr_state_t state;
    bstr_pkg::bstr_state_t next_state;

    always_comb begin
        case (state)
            bstr_pkg::ST_RESET:
                next_state = tms_s ? bstr_pkg::ST_RESET : bstr_pkg::ST_IDLE;
            bstr_pkg::ST_IDLE:
                next_state = tms_s ? bstr_pkg::ST_SEL_DR : bstr_pkg::ST_IDLE;
            bstr_pkg::ST_SEL_DR:
                next_state = tms_s ? bstr_pkg::ST_SEL_IR : bstr_pkg::ST_CAP_DR;
            bstr_pkg::ST_CAP_DR:
                next_state = tms_s ? bstr_pkg::ST_EXIT1_DR
                                   : bstr_pkg::ST_SHIFT_DR;
            bstr_pkg::ST_SHIFT_DR:
                next_state = tms_s ? bstr_pkg::ST_EXIT1_DR
                                   : bstr_pkg::ST_SHIFT_DR;
            bstr_pkg::ST_EXIT1_DR:
                next_state = tms_s ? bstr_pkg::ST_UPD_DR
                                   : bstr_pkg::ST_PAUSE_DR;
            bstr_pkg::ST_PAUSE_DR:
                next_state = tms_s ? bstr_pkg::ST_EXIT2_DR
                                   : bstr_pkg::ST_PAUSE_DR;
            bstr_pkg::ST_EXIT2_DR:
                next_state = tms_s ? bstr_pkg::ST_UPD_DR
                                   : bstr_pkg::ST_SHIFT_DR;
            bstr_pkg::ST_UPD_DR:
                next_state = tms_s ? bstr_pkg::ST_SEL_DR : bstr_pkg::ST_IDLE;
            bstr_pkg::ST_SEL_IR:
                next_state = tms_s ? bstr_pkg::ST_RESET : bstr_pkg::ST_CAP_IR;
            bstr_pkg::ST_CAP_IR:
                next_state = tms_s ? bstr_pkg::ST_EXIT1_IR
                                   : bstr_pkg::ST_SHIFT_IR;
            bstr_pkg::ST_SHIFT_IR:
                next_state = tms_s ? bstr_pkg::ST_EXIT1_IR
                                   : bstr_pkg::ST_SHIFT_IR;
            bstr_pkg::ST_EXIT1_IR:
                next_state = tms_s ? bstr_pkg::ST_UPD_IR
                                   : bstr_pkg::ST_PAUSE_IR;
            bstr_pkg::ST_PAUSE_IR:
                next_state = tms_s ? bstr_pkg::ST_EXIT2_IR
                                   : bstr_pkg::ST_PAUSE_IR;
            bstr_pkg::ST_EXIT2_IR:
                next_state = tms_s ? bstr_pkg::ST_UPD_IR
                                   : bstr_pkg::ST_SHIFT_IR;
            bstr_pkg::ST_UPD_IR:
                next_state = tms_s ? bstr_pkg::ST_SEL_DR : bstr_pkg::ST_IDLE;
            default:
                next_state = bstr_pkg::ST_RESET;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= bstr_pkg::ST_RESET;
        end else if (tck_rise) begin
            state <= next_state;
        end
    end

    // ****************************************************************
    // Instruction decode
    // ****************************************************************
    logic [`BSTR_IR_LEN-1:0] instr;
    wire op_extest = instr == `BSTR_OP_EXTEST;
    wire op_sample = instr == `BSTR_OP_SAMPLE;
    wire op_idcode = instr == `BSTR_OP_IDCODE;
    wire op_highz = instr == `BSTR_OP_HIGHZ;
    wire op_clamp = instr == `BSTR_OP_CLAMP;
    wire sel_bsr = op_extest | op_sample;
    wire sel_id = op_idcode;
    wire sel_bypass = ~sel_bsr & ~sel_id;
    wire next_test_mode = op_extest | op_clamp | op_highz;

    wire in_reset = state == bstr_pkg::ST_RESET;
    wire cap_dr = tck_rise & (state == bstr_pkg::ST_CAP_DR);
    wire sh_dr = tck_rise & (state == bstr_pkg::ST_SHIFT_DR);
    wire cap_ir = tck_rise & (state == bstr_pkg::ST_CAP_IR);
    wire sh_ir = tck_rise & (state == bstr_pkg::ST_SHIFT_IR);
    wire upd_dr = tck_fall & (state == bstr_pkg::ST_UPD_DR);
    wire upd_ir = tck_fall & (state == bstr_pkg::ST_UPD_IR);

    // ****************************************************************
    // Instruction shift stage and shadow
    // ****************************************************************
    logic [`BSTR_IR_LEN-1:0] ir_shift;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ir_shift <= `BSTR_IR_RESET;
        end else if (cap_ir) begin
            ir_shift <= `BSTR_IR_CAPTURE;
        end else if (sh_ir) begin
            ir_shift <= {tdi_s, ir_shift[`BSTR_IR_LEN-1:1]};
        end
    end

    // The shadow moves only on the update strobe or in Test-Logic-Reset, so an instruction
    // arriving with bad parity is still obeyed; checking is the tester's.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            instr <= `BSTR_IR_RESET;
            test_mode <= 1'b0;
        end else if (clk_en && in_reset) begin
            instr <= `BSTR_IR_RESET;
            test_mode <= 1'b0;
        end else if (upd_ir) begin
            instr <= ir_shift;
            test_mode <= 1'b0;
        end else if (clk_en) begin
            test_mode <= next_test_mode;
        end
    end

    // ****************************************************************
    // Data registers
    // ****************************************************************
    logic [`BSTR_BSR_LEN-1:0] bsr_shift;
    logic [`BSTR_ID_LEN-1:0] id_shift;
    logic bypass;

    // Each I/O cell captures the pin level whichever way it points.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bsr_shift <= {`BSTR_OE_RESET, {(`BSTR_BSR_LEN-4){1'b0}}};
        end else if (cap_dr && sel_bsr) begin
            bsr_shift <= level_s;
        end else if (sh_dr && sel_bsr) begin
            bsr_shift <= {tdi_s, bsr_shift[`BSTR_BSR_LEN-1:1]};
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cell_drive <= {`BSTR_OE_RESET, {(`BSTR_BSR_LEN-4){1'b0}}};
        end else if (clk_en && in_reset) begin
            cell_drive[`BSTR_OE_MSB:`BSTR_OE_LSB] <= `BSTR_OE_RESET;
        end else if (upd_dr && sel_bsr) begin
            cell_drive <= bsr_shift;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            id_shift <= '0;
            bypass <= 1'b0;
        end else begin
            if (cap_dr && sel_id) begin
                id_shift <= ID_VALUE;
            end else if (sh_dr && sel_id) begin
                id_shift <= {tdi_s, id_shift[`BSTR_ID_LEN-1:1]};
            end
            if (cap_dr && sel_bypass) begin
                bypass <= `BSTR_BYPASS_CAPTURE;
            end else if (sh_dr && sel_bypass) begin
                bypass <= tdi_s;
            end
        end
    end

    // Enable cells are active low; high impedance mode overrides them.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            port_drive <= 4'h0;
        end else if (clk_en) begin
            port_drive <= {4{test_mode & ~op_highz}} &
                ~cell_drive[`BSTR_OE_MSB:`BSTR_OE_LSB];
        end
    end

    // ****************************************************************
    // Serial output on the falling edge
    // ****************************************************************
    wire dr_lsb = sel_bsr ? bsr_shift[0] : (sel_id ? id_shift[0] : bypass);
    wire in_sh_ir = state == bstr_pkg::ST_SHIFT_IR;
    wire in_sh_dr = state == bstr_pkg::ST_SHIFT_DR;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tdo <= 1'b0;
            tdo_oe_n <= 1'b1;
        end else if (tck_fall) begin
            tdo <= in_sh_ir ? ir_shift[0] : dr_lsb;
            tdo_oe_n <= ~(in_sh_ir | in_sh_dr);
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    exit_dr_hiz_a: assert property (tck_fall && state ==
        bstr_pkg::ST_EXIT1_DR |=> tdo_oe_n)
        else $error("output still driven in data exit");
    exit_ir_hiz_a: assert property (tck_fall && state ==
        bstr_pkg::ST_EXIT1_IR |=> tdo_oe_n)
        else $error("output still driven in instruction exit");
    ir_drive_lsb_a: assert property (tck_fall && in_sh_ir
        |=> !tdo_oe_n && tdo == $past(ir_shift[0]))
        else $error("instruction LSB not driven out");
    ir_capture_a: assert property (cap_ir
        |=> ir_shift == `BSTR_IR_CAPTURE)
        else $error("instruction capture pattern wrong");
    ir_shift_step_a: assert property (sh_ir
        |=> ir_shift == {$past(tdi_s), $past(ir_shift[`BSTR_IR_LEN-1:1])})
        else $error("instruction shift step wrong");
    dr_pause_hold_a: assert property (tck_rise &&
        state == bstr_pkg::ST_PAUSE_DR |=> $stable(bsr_shift)
        && $stable(id_shift) && $stable(bypass))
        else $error("data changed in pause");
    ir_pause_hold_a: assert property (tck_rise &&
        state == bstr_pkg::ST_PAUSE_IR |=> $stable(ir_shift))
        else $error("instruction changed in pause");
    ir_update_a: assert property (upd_ir
        |=> instr == $past(ir_shift))
        else $error("instruction not updated");
    reset_values_a: assert property (clk_en && in_reset
        |=> instr == `BSTR_IR_RESET
        && cell_drive[`BSTR_OE_MSB:`BSTR_OE_LSB] == `BSTR_OE_RESET)
        else $error("reset values not applied");
    bypass_zero_a: assert property (cap_dr && sel_bypass
        |=> !bypass)
        else $error("bypass did not capture zero");
    tap_idle_a: assert property (tck_rise && in_reset && !tms_s
        |=> state == bstr_pkg::ST_IDLE)
        else $error("reset did not step to idle");

endmodule

// [bench/bstr_tester.sv]
`timescale 1ns/1ns
module bstr_tester (
    // Clock
    input wire logic sys_clk,
    // Test access pins
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe_n
);
    logic oe_ok;

    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        oe_ok = 1'b1;
    end

    // ****************************************************************
    // One test clock period
    // ****************************************************************
    // Inputs move together with the fall and stay put well past the rise.
    // The output is read late in the low phase, once it has settled.
    task automatic step(input logic m, input logic d, input logic want_oe_n,
                        output logic q);
        @(posedge sys_clk);
        tck <= 1'b0;
        tms <= m;
        tdi <= d;
        repeat (15) @(posedge sys_clk);
        q = tdo;
        if (tdo_oe_n !== want_oe_n) begin
            oe_ok = 1'b0;
        end
        tck <= 1'b1;
        repeat (15) @(posedge sys_clk);
    endtask

    task automatic to_idle();
        logic q;
        repeat (5) step(1'b1, 1'b1, 1'b1, q);
        step(1'b0, 1'b1, 1'b1, q);
    endtask

    // ****************************************************************
    // Whole scan from Run-Test/Idle back to Run-Test/Idle
    // ****************************************************************
    // A pause splits the shift so that the exit, pause and resume path
    // is taken with tdi held high, which would corrupt a leaky register.
    task automatic scan(input logic ir, input int n, input int pause_at,
                        input logic [63:0] din, output logic [63:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b1, 1'b1, q);
        if (ir) begin
            step(1'b1, 1'b1, 1'b1, q);
        end
        step(1'b0, 1'b1, 1'b1, q);
        step(1'b0, 1'b1, 1'b1, q);
        for (int i = 0; i < n; i++) begin
            step((i == n - 1) || (i == pause_at - 1), din[i], 1'b0, q);
            dout[i] = q;
            if (i == pause_at - 1) begin
                repeat (3) step(1'b0, 1'b1, 1'b1, q);
                step(1'b1, 1'b1, 1'b1, q);
                step(1'b0, 1'b1, 1'b1, q);
            end
        end
        step(1'b1, 1'b1, 1'b1, q);
        step(1'b0, 1'b1, 1'b1, q);
    endtask
endmodule

// [bench/bstr_tap_tb_top.sv]
`timescale 1ns/1ns
`include "bstr_cfg.svh"
module bstr_tap_tb_top;
    logic sys_clk;
    logic rst;
    logic clk_en;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe_n;
    logic [47:0] pin_level;
    logic [47:0] cell_drive;
    logic test_mode;
    logic [3:0] port_drive;
    logic [63:0] got;
    int fail_count;
    int checks;
    int cycles;
    // Codes keep even parity; expected mode bit per entry below.
    localparam logic [7:0] CODES [6] = '{`BSTR_OP_EXTEST, `BSTR_OP_SAMPLE,
        `BSTR_OP_HIGHZ, `BSTR_OP_CLAMP, `BSTR_OP_IDCODE, 8'hff};
    localparam logic [5:0] MODES = 6'b001101;
    localparam logic [47:0] PINS = 48'ha5c3_1e0f_9b27;
    localparam logic [47:0] LOAD1 = 48'h5123_4567_89ab;
    localparam logic [47:0] LOAD2 = 48'h3000_0000_00c1;

    initial sys_clk = 1'b0;
    always #2 sys_clk = ~sys_clk;

    bstr_tap dut (
        .sys_clk(sys_clk),
        .rst(rst),
        .clk_en(clk_en),
        .tck(tck),
        .tms(tms),
        .tdi(tdi),
        .tdo(tdo),
        .tdo_oe_n(tdo_oe_n),
        .pin_level(pin_level),
        .cell_drive(cell_drive),
        .test_mode(test_mode),
        .port_drive(port_drive)
    );

    bstr_tester tester (
        .sys_clk(sys_clk),
        .tck(tck),
        .tms(tms),
        .tdi(tdi),
        .tdo(tdo),
        .tdo_oe_n(tdo_oe_n)
    );

    // ****************************************************************
    // Comparison, verdict and watchdog
    // ****************************************************************
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // About 10000 cycles are expected; the ceiling leaves ample room.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            fail_count++;
            close_out();
        end
    end

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        rst = 1'b1;
        clk_en = 1'b1;
        pin_level = 48'h0;
        fail_count = 0;
        checks = 0;
        cycles = 0;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        check(64'(cell_drive), 64'h0000_f000_0000_0000);
        check(64'({test_mode, port_drive, tdo_oe_n}), 64'h1);
        tester.to_idle();
        $display("reset test done");
        for (int i = 0; i < 6; i++) begin
            tester.scan(1'b1, 8, (i == 0) ? 3 : 0, 64'(CODES[i]), got);
            check(64'(got[7:0]), 64'h81);
            check(64'(test_mode), 64'(MODES[i]));
        end
        $display("instruction test done");
        tester.scan(1'b0, 2, 0, 64'h1, got);
        check(64'(got[1:0]), 64'h2);
        // A test clock period with the enable low must leave the
        // controller in Run-Test/Idle, so the next scan still matches.
        clk_en <= 1'b0;
        tester.step(1'b1, 1'b1, 1'b1, got[0]);
        clk_en <= 1'b1;
        tester.scan(1'b0, 2, 0, 64'h1, got);
        check(64'(got[1:0]), 64'h2);
        tester.scan(1'b1, 8, 0, 64'(`BSTR_OP_IDCODE), got);
        tester.scan(1'b0, 32, 0, 64'h0, got);
        check(64'(got[31:0]), 64'(`BSTR_ID_DEFAULT));
        $display("bypass and identity test done");
        pin_level <= PINS;
        tester.scan(1'b1, 8, 0, 64'(`BSTR_OP_SAMPLE), got);
        tester.scan(1'b0, 48, 20, 64'(LOAD1), got);
        check(64'(got[47:0]), 64'(PINS));
        check(64'(cell_drive), 64'(LOAD1));
        check(64'({test_mode, port_drive}), 64'h0);
        $display("sample test done");
        tester.scan(1'b1, 8, 0, 64'(`BSTR_OP_EXTEST), got);
        check(64'(port_drive), 64'h0000_000a);
        tester.scan(1'b0, 48, 0, 64'(LOAD2), got);
        check(64'(got[47:0]), 64'(PINS));
        check(64'(cell_drive), 64'(LOAD2));
        check(64'(port_drive), 64'h0000_000c);
        $display("extest test done");
        tester.scan(1'b1, 8, 0, 64'(`BSTR_OP_HIGHZ), got);
        check(64'({test_mode, port_drive}), 64'h10);
        tester.to_idle();
        check(64'(test_mode), 64'h0);
        check(64'(cell_drive[47:44]), 64'hf);
        check(64'(tester.oe_ok), 64'h1);
        $display("test reset test done");
        close_out();
    end
endmodule
